// ### hdl/branch_resolve_unit.sv
/*
 Branch resolve unit: decodes negative-test and unequal-compare branches and
 the breakpoint trap, resolves them in the branch cycle and steers the PC in
 the delay-slot cycle. Assumes decode presents one instruction per cycle with
 instr_valid and its register operands already read.
*/
// Notes on behaviour
// [RULE1] Target is delay-slot address plus sign-extended offset shifted left by two.
// [RULE2] Negative-test branches are taken when the tested register's top bit is one.
// [RULE3] Unequal-compare branches are taken when the two registers differ anywhere.
// [RULE4] A taken branch runs its delay slot first, then fetch goes to target.
// [RULE5] Likely forms squash the delay slot when not taken.
// [RULE6] Linking forms write branch address plus eight to register 31 always.
// [RULE7] Condition is resolved in the branch cycle; the PC moves in the delay slot.
// [RULE8] Software must not test register 31 in a linking branch; result undefined.
// [RULE9] A delay-slot exception resumes by re-executing the branch itself.
// [RULE10] Breakpoint raises its exception at once and unconditionally.
// [RULE11] The breakpoint code field is ignored by the hardware.
// [RULE12] Non-likely branches raise no exception of their own.
// [RULE13] Negative tests decode from the group's bits 20..16; compares from own opcodes.
`timescale 1ns/1ps
`default_nettype none
module branch_resolve_unit
  import branch_resolve_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] first_source_register,
  input wire logic [31:0] second_source_register,
  input wire logic exception_in_slot,
  output logic link_write,
  output logic [4:0] link_index,
  output logic [31:0] link_value,
  output logic redirect,
  output logic [31:0] redirect_pc,
  output logic squash_current_instruction,
  output logic breakpoint_exception,
  output logic [31:0] exception_resume_pc,
  output logic in_delay_slot
);
  logic [5:0] opc;
  logic [4:0] sub;
  logic is_neg;
  logic is_neg_l;
  logic is_neg_link;
  logic is_neg_link_l;
  logic is_ne;
  logic is_ne_l;
  logic is_branch;
  logic is_likely;
  logic is_link;
  logic cond;
  logic is_break;
  logic [31:0] offset_ext;
  logic [31:0] target;
  logic pend_q;
  logic pend_taken_q;
  logic pend_likely_q;
  logic [31:0] pend_target_q;
  logic [31:0] pend_branch_pc_q;

  assign opc = instr[OPC_MSB:OPC_LSB];
  assign sub = instr[SECOND_MSB:SECOND_LSB];
  // Negative tests from the group sub-field, compares from their own opcodes. [RULE13]
  assign is_neg = opc == OPC_REGISTER_IMMEDIATE_GROUP && sub == SUB_NEGATIVE;
  assign is_neg_l = opc == OPC_REGISTER_IMMEDIATE_GROUP && sub == SUB_NEGATIVE_LIKELY;
  assign is_neg_link = opc == OPC_REGISTER_IMMEDIATE_GROUP && sub == SUB_NEGATIVE_LINK;
  assign is_neg_link_l = opc == OPC_REGISTER_IMMEDIATE_GROUP
    && sub == SUB_NEGATIVE_LINK_LIKELY;
  assign is_ne = opc == OPC_UNEQUAL;
  assign is_ne_l = opc == OPC_UNEQUAL_LIKELY;
  // The code field in bits 25..6 is not looked at. [RULE11]
  assign is_break = opc == OPC_SPECIAL && instr[FUNC_MSB:0] == FUNC_BREAKPOINT;
  assign is_branch = instr_valid
    && (is_neg || is_neg_l || is_neg_link || is_neg_link_l || is_ne || is_ne_l);
  assign is_likely = is_neg_l || is_neg_link_l || is_ne_l;
  assign is_link = is_neg_link || is_neg_link_l;

  always_comb
  begin
    if (is_ne || is_ne_l)
    begin
      cond = first_source_register != second_source_register; // [RULE3]
    end
    else
    begin
      cond = first_source_register[31]; // [RULE2]
    end
  end

  // Offset shifted by two and sign-extended, added to the delay-slot address. [RULE1]
  assign offset_ext = {{14{instr[OFFSET_MSB]}}, instr[OFFSET_MSB:0], 2'b00};
  assign target = instr_pc + SLOT_DISTANCE + offset_ext;

  // Resolution captured in the branch cycle, applied in the next. [RULE7]
  // A cycle with instr_valid low is a stall: the pending branch is held, so
  // redirect and squash stay up until the delay slot really issues. The
  // trade-off is that fetch must not advance while it sees them held.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q <= 1'b0;
      pend_taken_q <= 1'b0;
      pend_likely_q <= 1'b0;
      pend_target_q <= PC_RESET;
      pend_branch_pc_q <= PC_RESET;
    end
    else if (instr_valid)
    begin
      pend_q <= is_branch;
      pend_taken_q <= is_branch && cond;
      pend_likely_q <= is_branch && is_likely;
      pend_target_q <= target;
      pend_branch_pc_q <= instr_pc;
    end
  end

  // Link write raised in the cycle after the branch, stall or delay slot, whatever the condition. [RULE6]
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_write <= 1'b0;
      link_index <= 5'h00;
      link_value <= PC_RESET;
    end
    else
    begin
      link_write <= is_branch && is_link;
      link_index <= LINK_REGISTER;
      link_value <= instr_pc + LINK_DISTANCE;
    end
  end

  // The delay slot always runs on a taken branch; the redirect follows it. [RULE4]
  assign redirect = pend_q && pend_taken_q;
  assign redirect_pc = pend_target_q;
  // Untaken likely forms drop the slot; non-likely forms never trap. [RULE5] [RULE12]
  assign squash_current_instruction = pend_q && pend_likely_q && !pend_taken_q;
  assign in_delay_slot = pend_q;
  // Breakpoint asserted combinationally in its decode cycle. [RULE10]
  assign breakpoint_exception = instr_valid && is_break;
  // Slot exceptions resume at the branch; linking branch tests of r31 are not guarded. [RULE9] [RULE8]
  assign exception_resume_pc = (pend_q && exception_in_slot) ? pend_branch_pc_q : instr_pc;

  // The multi-step behaviours are spelled out once as sequences, so that the
  // properties below read as cause and effect.
  sequence s_linking_branch;
    is_branch && is_link;
  endsequence

  sequence s_taken_branch;
    is_branch && cond;
  endsequence

  sequence s_untaken_likely;
    is_branch && is_likely && !cond;
  endsequence

  sequence s_branch_then_slot_fault;
    is_branch ##1 exception_in_slot;
  endsequence

  a_link_value: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
    s_linking_branch |=> link_write && link_value == $past(instr_pc) + LINK_DISTANCE)
    else $error("link not written");
  a_link_index: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
    s_linking_branch |=> link_index == LINK_REGISTER)
    else $error("link written to wrong register");
  a_no_link_plain: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
    (instr_valid && !(is_branch && is_link)) |=> !link_write)
    else $error("link written by non-linking instruction");
  a_redirect_next: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
    s_taken_branch |=> redirect && redirect_pc == $past(target))
    else $error("taken branch not redirected");
  a_slot_flag: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
    is_branch |=> in_delay_slot)
    else $error("delay slot not marked");
  // The target is checked as a signed offset so that it does not merely
  // restate the concatenation used by the logic.
  a_target_calc: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    is_branch |-> $signed(target - instr_pc - SLOT_DISTANCE)
      == $signed(instr[OFFSET_MSB:0]) * 4)
    else $error("bad target");
  a_neg_cond: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
    (is_branch && opc == OPC_REGISTER_IMMEDIATE_GROUP)
      |=> redirect == $past(first_source_register[31]))
    else $error("negative test wrong");
  a_ne_cond: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
    (is_branch && (opc == OPC_UNEQUAL || opc == OPC_UNEQUAL_LIKELY)) |=>
    redirect == ($past(first_source_register) != $past(second_source_register)))
    else $error("compare wrong");
  a_group_decode: assert property (@(posedge clk) disable iff (!reset_n) // [RULE13]
    (instr_valid && opc == OPC_REGISTER_IMMEDIATE_GROUP && sub != SUB_NEGATIVE
      && sub != SUB_NEGATIVE_LIKELY && sub != SUB_NEGATIVE_LINK
      && sub != SUB_NEGATIVE_LINK_LIKELY) |=> !in_delay_slot)
    else $error("unknown group code taken as branch");
  a_squash_likely: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
    s_untaken_likely |=> squash_current_instruction && !redirect)
    else $error("likely slot not squashed");
  a_no_squash: assert property (@(posedge clk) disable iff (!reset_n) // [RULE12]
    (is_branch && !is_likely) |=> !squash_current_instruction)
    else $error("non-likely slot squashed");
  a_slot_resume: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
    s_branch_then_slot_fault |-> exception_resume_pc == $past(instr_pc))
    else $error("resume not at branch");
  a_break_now: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
    (instr_valid && opc == OPC_SPECIAL && instr[FUNC_MSB:0] == FUNC_BREAKPOINT)
      |-> breakpoint_exception)
    else $error("breakpoint missed");
  // Whatever the code field holds, the trap follows the opcode and function alone.
  a_break_code_free: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    breakpoint_exception |-> instr_valid && opc == OPC_SPECIAL
      && instr[FUNC_MSB:0] == FUNC_BREAKPOINT)
    else $error("breakpoint raised without its encoding");
  a_taken_slot: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
    s_taken_branch |=> !squash_current_instruction)
    else $error("taken slot squashed");
endmodule
`default_nettype wire

// ### hdl/branch_resolve_pkg.sv
/*
 Shared constants for the branch resolve unit: opcode fields and encodings.
 Assumes a 32-bit instruction word and 32-bit general registers.
*/
package branch_resolve_pkg;
  localparam int unsigned OPC_MSB = 31;
  localparam int unsigned OPC_LSB = 26;
  localparam int unsigned FIRST_MSB = 25;
  localparam int unsigned FIRST_LSB = 21;
  localparam int unsigned SECOND_MSB = 20;
  localparam int unsigned SECOND_LSB = 16;
  localparam int unsigned OFFSET_MSB = 15;
  localparam int unsigned FUNC_MSB = 5;
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_REGISTER_IMMEDIATE_GROUP = 6'h01;
  localparam logic [5:0] OPC_UNEQUAL = 6'h05;
  localparam logic [5:0] OPC_UNEQUAL_LIKELY = 6'h15;
  localparam logic [5:0] FUNC_BREAKPOINT = 6'h0D;
  localparam logic [4:0] SUB_NEGATIVE = 5'h00;
  localparam logic [4:0] SUB_NEGATIVE_LIKELY = 5'h02;
  localparam logic [4:0] SUB_NEGATIVE_LINK = 5'h10;
  localparam logic [4:0] SUB_NEGATIVE_LINK_LIKELY = 5'h12;
  localparam logic [4:0] LINK_REGISTER = 5'h1F;
  localparam logic [31:0] LINK_DISTANCE = 32'h0000_0008;
  localparam logic [31:0] SLOT_DISTANCE = 32'h0000_0004;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
endpackage

// ### test/fetch_model.sv
/*
 Fetch-side partner: follows redirects and holds register 31.
 Assumes the single clock and the active-low reset of the unit.
*/
`timescale 1ns/1ps
`default_nettype none
module fetch_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_write,
  input wire logic [4:0] link_index,
  input wire logic [31:0] link_value,
  input wire logic redirect,
  input wire logic [31:0] redirect_pc,
  output logic [31:0] link_reg,
  output logic [31:0] fetch_pc
);
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) link_reg <= 32'h0;
    else if (link_write && link_index == 5'h1F) link_reg <= link_value;
  // Fetch moves only at the end of the delay slot, never at the branch.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) fetch_pc <= 32'h0;
    else if (redirect) fetch_pc <= redirect_pc;
endmodule
`default_nettype wire

// ### test/branch_resolve_unit_tb.sv
/*
 Testbench for the branch resolve unit with the fetch partner.
 Assumes a 40 MHz clock and inputs driven 2 ns after each rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module branch_resolve_unit_tb;
  import branch_resolve_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, iv = 1'b0, exc = 1'b0;
  logic [31:0] ins = 32'h0, ipc = 32'h0, sa = 32'h0, sb = 32'h0, lreg, fpc;
  logic lw, rd, sq, bk, ds;
  logic [4:0] li;
  logic [31:0] lv, rpc, epc;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  branch_resolve_unit dut (.clk(clk), .reset_n(reset_n), .instr_valid(iv), .instr(ins),
    .instr_pc(ipc), .first_source_register(sa), .second_source_register(sb),
    .exception_in_slot(exc), .link_write(lw), .link_index(li), .link_value(lv),
    .redirect(rd), .redirect_pc(rpc), .squash_current_instruction(sq),
    .breakpoint_exception(bk), .exception_resume_pc(epc), .in_delay_slot(ds));
  fetch_model partner (.clk(clk), .reset_n(reset_n), .link_write(lw), .link_index(li),
    .link_value(lv), .redirect(rd), .redirect_pc(rpc), .link_reg(lreg), .fetch_pc(fpc));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 3000)
  begin
    n_mismatch++;
    test_done();
  end
  // One branch, its delay slot, then an idle cycle; ex raises a slot exception.
  task automatic br(input logic [5:0] op, input logic [4:0] sub, input logic [31:0] a,
    input logic [31:0] b, input logic [15:0] off, input logic tk, input logic lk,
    input logic ln, input logic ex);
    logic [31:0] pc;
    pc = 32'h0000_2000 + {16'h0, off};
    @(posedge clk) #2 iv = 1'b1;
    ins = {op, 5'h03, sub, off};
    ipc = pc;
    sa = a;
    sb = b;
    #1 chk(bk, 0);
    chk(rd, 0);
    @(posedge clk) #2 ins = 32'h0;
    ipc = pc + 32'h4;
    exc = ex;
    #1 chk(rd, tk);
    if (tk) chk(rpc, pc + 32'h4 + {{14{off[15]}}, off, 2'b00});
    chk(sq, lk & !tk);
    chk(lw, ln);
    if (ln) chk(lv, pc + 32'h8);
    chk(ds, 1);
    if (ex) chk(epc, pc);
    @(posedge clk) #2 iv = 1'b0;
    exc = 1'b0;
    #1 chk(rd, 0);
    if (tk) chk(fpc, pc + 32'h4 + {{14{off[15]}}, off, 2'b00});
    if (ln) chk(lreg, pc + 32'h8);
  endtask
  task automatic test_negative();
    logic [4:0] subs [4] = '{SUB_NEGATIVE, SUB_NEGATIVE_LIKELY, SUB_NEGATIVE_LINK,
      SUB_NEGATIVE_LINK_LIKELY};
    for (int i = 0; i < 4; i++)
    begin
      br(OPC_REGISTER_IMMEDIATE_GROUP, subs[i], 32'h8000_0000, 0, 16'h8000, 1,
        subs[i][1], subs[i][4], 0);
      br(OPC_REGISTER_IMMEDIATE_GROUP, subs[i], 32'h7FFF_FFFF, 0, 16'h7FFF, 0,
        subs[i][1], subs[i][4], i == 0);
    end
    $display("test_negative done");
  endtask
  task automatic test_unequal();
    br(OPC_UNEQUAL, 5'h04, 32'h1234_5679, 32'h1234_5678, 16'hFFFF, 1, 0, 0, 1);
    br(OPC_UNEQUAL, 5'h04, 32'h8000_0001, 32'h8000_0001, 16'h0010, 0, 0, 0, 0);
    br(OPC_UNEQUAL_LIKELY, 5'h04, 32'h0, 32'h8000_0000, 16'h0004, 1, 1, 0, 0);
    br(OPC_UNEQUAL_LIKELY, 5'h04, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0004, 0, 1, 0, 0);
    $display("test_unequal done");
  endtask
  task automatic test_break();
    @(posedge clk) #2 iv = 1'b1;
    ins = {OPC_SPECIAL, 20'hFFFFF, FUNC_BREAKPOINT};
    #1 chk(bk, 1);
    @(posedge clk) #2 ins = {OPC_SPECIAL, 20'h0, FUNC_BREAKPOINT};
    #1 chk(bk, 1);
    @(posedge clk) #2 iv = 1'b0;
    $display("test_break done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #2 reset_n = 1'b1;
    test_negative();
    test_unequal();
    test_break();
    test_done();
  end
endmodule
`default_nettype wire
